//--- shared/bfs_regs.vh
// Constants of the buck fault and diode-mode supervisor
// What this block does
// RULE1: Diode mode is entered only after eight switching cycles in a row each saw negative current while the low-side gate was high.
// RULE2: In diode mode, once a negative voltage across the low-side switch is seen, diode mode ends at the next switching pulse.
// RULE3: Entering diode mode widens the ripple window so the switching rate drops by about thirty percent.
// RULE4: Leaving diode mode removes the widening at once, restoring the nominal switching rate.
// RULE5: An overcurrent fault is declared only when the current sense stays above the output sense for more than 10 us without a break.
// RULE6: An overcurrent fault latches the converter off and pulls power good low.
// RULE7: Any latched fault holds until the enable falls below its threshold or the bias supply falls below its reset threshold.
// RULE8: An overvoltage fault is declared when feedback stays above the rising overvoltage threshold for more than 2 us.
// RULE9: An overvoltage fault latches the converter off and pulls power good low.
// RULE10: While latched for overvoltage, the low-side switch turns off after feedback is below the falling threshold for more than 2 us.
// RULE11: While latched for overvoltage, the low-side switch turns on again after feedback is above the rising threshold for more than 2 us.
// RULE12: An undervoltage fault is declared after feedback stays below its threshold for more than 2 us, latching off with power good low.
// RULE13: Over-temperature holds both gates low without latching or touching power good, and other protections keep working.
// RULE14: The diode-mode entry count restarts from zero after any switching cycle without negative current.
// RULE15: While any fault is latched the high-side gate stays low and only overvoltage discharge may drive the low-side gate.
`ifndef BFS_REGS_VH
`define BFS_REGS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define BFS_CLK_PERIOD_NS 10
`define BFS_OC_TIME_NS 10000
`define BFS_OV_TIME_NS 2000
`define BFS_OC_CYC (`BFS_OC_TIME_NS / `BFS_CLK_PERIOD_NS)
`define BFS_OV_CYC (`BFS_OV_TIME_NS / `BFS_CLK_PERIOD_NS)
`define BFS_DEM_ENTRY_CYC 8
`define BFS_WIDEN_PCT 30

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define BFS_CTRL_ADDR 8'h00
`define BFS_STATUS_ADDR 8'h04
`define BFS_IRQ_STAT_ADDR 8'h08
`define BFS_IRQ_CLR_ADDR 8'h0C
`define BFS_IRQ_EN_ADDR 8'h10
`define BFS_DEM_CNT_ADDR 8'h14

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BFS_CTRL_RUN_BIT 0
`define BFS_CTRL_RST 1'h0
`define BFS_ST_OC_BIT 0
`define BFS_ST_OV_BIT 1
`define BFS_ST_UV_BIT 2
`define BFS_ST_OT_BIT 3
`define BFS_ST_DEM_BIT 4
`define BFS_ST_PG_BIT 5
`define BFS_ST_DIS_BIT 6
`define BFS_IRQ_OC_BIT 0
`define BFS_IRQ_OV_BIT 1
`define BFS_IRQ_UV_BIT 2
`define BFS_IRQ_OT_BIT 3
`define BFS_IRQ_DEM_IN_BIT 4
`define BFS_IRQ_DEM_OUT_BIT 5
`define BFS_IRQ_W 6
`define BFS_IRQ_RST 6'h00

`endif

//--- rtl/bfs_filt.v
// Pin synchroniser with an optional continuous-level qualifier
module bfs_filt #(
    parameter CNT = 0,
    parameter CW = 11
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rstn_in,
    // Pin and result
    input wire pin_in,
    output wire level_out
);

    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    reg lvl_ff;
    reg [CW-1:0] cnt_ff;
    reg [CW-1:0] nxt_cnt;

    // ****************************************************************
    // Three-stage capture; a change counts once stages two and three agree
    // ****************************************************************
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            lvl_ff <= 1'b0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                lvl_ff <= s3_ff;
            end
        end
    end

    // ****************************************************************
    // Qualifier: true only after more than CNT cycles of steady level
    // ****************************************************************
    always @* begin
        nxt_cnt = cnt_ff;
        if (!lvl_ff) begin
            nxt_cnt = {CW{1'b0}};
        end else if (cnt_ff != CNT[CW-1:0]) begin
            nxt_cnt = cnt_ff + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_ff <= {CW{1'b0}};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign level_out = lvl_ff && (cnt_ff == CNT[CW-1:0]);

endmodule // bfs_filt

//--- rtl/bfs_top.v
// Fault latches, diode-mode control and register slave of the supervisor
`include "bfs_regs.vh"
module bfs_top #(
    parameter DEM_ENTRY = `BFS_DEM_ENTRY_CYC,
    parameter OC_CYC = `BFS_OC_CYC,
    parameter OV_CYC = `BFS_OV_CYC
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rstn_in,
    // Wishbone classic slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output wire [31:0] wb_dat_out,
    output wire wb_ack_out,
    // Comparator results
    input wire current_limit_sense_above_in,
    input wire feedback_pin_above_ov_rise_in,
    input wire feedback_pin_below_ov_fall_in,
    input wire feedback_pin_below_uv_in,
    input wire enable_below_fall_in,
    input wire bias_supply_pin_below_por_in,
    input wire over_temp_in,
    input wire neg_current_in,
    input wire neg_voltage_in,
    // Modulator gate requests
    input wire pwm_high_req_in,
    input wire pwm_low_req_in,
    // Gate, window and status outputs
    output wire high_side_gate_out,
    output wire low_side_gate_out,
    output wire power_good_output_out,
    output wire light_load_diode_mode_out,
    output wire window_widen_out,
    output wire irq_out
);

    wire oc_q;
    wire ovr_q;
    wire ovf_q;
    wire uv_q;
    wire en_low;
    wire por_low;
    wire ot;
    wire negi;
    wire negv;
    wire pwm_h;
    wire pwm_l;

    // ****************************************************************
    // Pin capture and deglitch
    // ****************************************************************
    bfs_filt #(.CNT(OC_CYC)) u_oc (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(current_limit_sense_above_in), .level_out(oc_q)); // RULE5
    bfs_filt #(.CNT(OV_CYC)) u_ovr (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(feedback_pin_above_ov_rise_in), .level_out(ovr_q)); // RULE8
    bfs_filt #(.CNT(OV_CYC)) u_ovf (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(feedback_pin_below_ov_fall_in), .level_out(ovf_q));
    bfs_filt #(.CNT(OV_CYC)) u_uv (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(feedback_pin_below_uv_in), .level_out(uv_q)); // RULE12
    bfs_filt u_en (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(enable_below_fall_in), .level_out(en_low));
    bfs_filt u_por (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(bias_supply_pin_below_por_in), .level_out(por_low));
    bfs_filt u_ot (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(over_temp_in), .level_out(ot));
    bfs_filt u_ni (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(neg_current_in), .level_out(negi));
    bfs_filt u_nv (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(neg_voltage_in), .level_out(negv));
    bfs_filt u_ph (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(pwm_high_req_in), .level_out(pwm_h));
    bfs_filt u_pl (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .pin_in(pwm_low_req_in), .level_out(pwm_l));

    // ****************************************************************
    // Fault latches
    // ****************************************************************
    reg oc_ff;
    reg ov_ff;
    reg uv_ff;
    reg dis_ff;
    reg run_ff;
    wire release_w;
    wire fault_w;

    assign release_w = en_low | por_low;
    assign fault_w = oc_ff | ov_ff | uv_ff;

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oc_ff <= 1'b0;
            ov_ff <= 1'b0;
            uv_ff <= 1'b0;
            dis_ff <= 1'b0;
        end else if (release_w) begin
            // Dropping enable or bias is the only way out of a latch
            oc_ff <= 1'b0; // RULE7
            ov_ff <= 1'b0; // RULE7
            uv_ff <= 1'b0; // RULE7
            dis_ff <= 1'b0;
        end else begin
            if (oc_q) begin
                oc_ff <= 1'b1; // RULE6
            end
            if (uv_q) begin
                uv_ff <= 1'b1; // RULE12
            end
            if (ovr_q) begin
                ov_ff <= 1'b1; // RULE9
                dis_ff <= 1'b1; // RULE11
            end else if (ovf_q) begin
                dis_ff <= 1'b0; // RULE10
            end
        end
    end

    // ****************************************************************
    // Switching cycle tracking and diode-mode control
    // ****************************************************************
    reg pwm_h_d_ff;
    reg neg_seen_ff;
    reg exit_pend_ff;
    reg dem_ff;
    reg [3:0] dem_cnt_ff;
    reg [3:0] nxt_dem_cnt;
    reg nxt_dem;
    wire cyc_start;
    wire active;

    // Over-temperature suspends only; faults keep being watched
    assign active = run_ff & ~release_w & ~fault_w & ~ot; // RULE13
    assign cyc_start = pwm_h & ~pwm_h_d_ff & active;

    always @* begin
        nxt_dem_cnt = dem_cnt_ff;
        nxt_dem = dem_ff;
        if (!active) begin
            nxt_dem_cnt = 4'h0;
            nxt_dem = 1'b0;
        end else if (cyc_start) begin
            if (dem_ff) begin
                if (exit_pend_ff) begin
                    nxt_dem = 1'b0; // RULE2
                    nxt_dem_cnt = 4'h0;
                end
            end else if (!neg_seen_ff) begin
                nxt_dem_cnt = 4'h0; // RULE14
            end else if (dem_cnt_ff == DEM_ENTRY[3:0] - 4'h1) begin
                nxt_dem = 1'b1; // RULE1
                nxt_dem_cnt = 4'h0;
            end else begin
                nxt_dem_cnt = dem_cnt_ff + 4'h1; // RULE1
            end
        end
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pwm_h_d_ff <= 1'b0;
            neg_seen_ff <= 1'b0;
            exit_pend_ff <= 1'b0;
            dem_ff <= 1'b0;
            dem_cnt_ff <= 4'h0;
        end else begin
            pwm_h_d_ff <= pwm_h;
            dem_ff <= nxt_dem;
            dem_cnt_ff <= nxt_dem_cnt;
            if (cyc_start || !active) begin
                neg_seen_ff <= 1'b0;
                exit_pend_ff <= 1'b0;
            end else begin
                if (negi && pwm_l) begin
                    neg_seen_ff <= 1'b1; // RULE1
                end
                if (dem_ff && negv) begin
                    exit_pend_ff <= 1'b1; // RULE2
                end
            end
        end
    end

    // ****************************************************************
    // Gate drive
    // ****************************************************************
    reg hg_ff;
    reg lg_ff;
    reg pg_ff;
    reg blk_ff;

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hg_ff <= 1'b0;
            lg_ff <= 1'b0;
            pg_ff <= 1'b0;
            blk_ff <= 1'b0;
        end else begin
            // In diode mode the low side opens once current reverses
            if (cyc_start || !dem_ff) begin
                blk_ff <= 1'b0;
            end else if (negi) begin
                blk_ff <= 1'b1;
            end
            if (fault_w) begin
                hg_ff <= 1'b0; // RULE15
                // Over-temperature outranks the discharge pulses
                lg_ff <= ov_ff & dis_ff & ~ot; // RULE15 RULE13
            end else begin
                hg_ff <= active & pwm_h; // RULE13
                lg_ff <= active & pwm_l & ~pwm_h
                    & ~(dem_ff & (blk_ff | negi)); // RULE13
            end
            pg_ff <= ~fault_w & ~release_w; // RULE6
        end
    end

    assign high_side_gate_out = hg_ff;
    assign low_side_gate_out = lg_ff;
    assign power_good_output_out = pg_ff;
    assign light_load_diode_mode_out = dem_ff;
    // Window widening follows the mode with no delay either way
    assign window_widen_out = dem_ff; // RULE3 RULE4

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    reg oc_d_ff;
    reg ov_d_ff;
    reg uv_d_ff;
    reg ot_d_ff;
    reg dem_d_ff;
    reg [`BFS_IRQ_W-1:0] ist_ff;
    reg [`BFS_IRQ_W-1:0] ien_ff;
    wire [`BFS_IRQ_W-1:0] ev;
    wire [`BFS_IRQ_W-1:0] clr;
    wire wr_stb;

    assign ev[`BFS_IRQ_OC_BIT] = oc_ff & ~oc_d_ff;
    assign ev[`BFS_IRQ_OV_BIT] = ov_ff & ~ov_d_ff;
    assign ev[`BFS_IRQ_UV_BIT] = uv_ff & ~uv_d_ff;
    assign ev[`BFS_IRQ_OT_BIT] = ot & ~ot_d_ff;
    assign ev[`BFS_IRQ_DEM_IN_BIT] = dem_ff & ~dem_d_ff;
    assign ev[`BFS_IRQ_DEM_OUT_BIT] = ~dem_ff & dem_d_ff;

    reg ack_ff;
    reg [31:0] dat_ff;
    assign wr_stb = wb_cyc_in & wb_stb_in & wb_we_in & ack_ff & wb_sel_in[0];
    assign clr = (wr_stb && wb_adr_in == `BFS_IRQ_CLR_ADDR) ?
        wb_dat_in[`BFS_IRQ_W-1:0] : {`BFS_IRQ_W{1'b0}};

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oc_d_ff <= 1'b0;
            ov_d_ff <= 1'b0;
            uv_d_ff <= 1'b0;
            ot_d_ff <= 1'b0;
            dem_d_ff <= 1'b0;
            ist_ff <= `BFS_IRQ_RST;
        end else begin
            oc_d_ff <= oc_ff;
            ov_d_ff <= ov_ff;
            uv_d_ff <= uv_ff;
            ot_d_ff <= ot;
            dem_d_ff <= dem_ff;
            // A new event outranks a clear in the same cycle
            ist_ff <= (ist_ff & ~clr) | ev;
        end
    end

    assign irq_out = |(ist_ff & ien_ff);

    // ****************************************************************
    // Wishbone slave: ack one cycle after the request, writes on ack
    // ****************************************************************
    wire [6:0] st_w;
    reg [31:0] rd_w;

    assign st_w = {dis_ff, pg_ff, dem_ff, ot, uv_ff, ov_ff, oc_ff};

    always @* begin
        rd_w = 32'h00000000;
        if (wb_adr_in == `BFS_CTRL_ADDR) begin
            rd_w[`BFS_CTRL_RUN_BIT] = run_ff;
        end else if (wb_adr_in == `BFS_STATUS_ADDR) begin
            rd_w[6:0] = st_w;
        end else if (wb_adr_in == `BFS_IRQ_STAT_ADDR) begin
            rd_w[`BFS_IRQ_W-1:0] = ist_ff;
        end else if (wb_adr_in == `BFS_IRQ_EN_ADDR) begin
            rd_w[`BFS_IRQ_W-1:0] = ien_ff;
        end else if (wb_adr_in == `BFS_DEM_CNT_ADDR) begin
            rd_w[3:0] = dem_cnt_ff;
        end
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
            run_ff <= `BFS_CTRL_RST;
            ien_ff <= `BFS_IRQ_RST;
        end else begin
            ack_ff <= wb_cyc_in & wb_stb_in & ~ack_ff;
            if (wb_cyc_in && wb_stb_in && !ack_ff) begin
                dat_ff <= rd_w;
            end
            if (wr_stb && wb_adr_in == `BFS_CTRL_ADDR) begin
                run_ff <= wb_dat_in[`BFS_CTRL_RUN_BIT];
            end
            if (wr_stb && wb_adr_in == `BFS_IRQ_EN_ADDR) begin
                ien_ff <= wb_dat_in[`BFS_IRQ_W-1:0];
            end
        end
    end

    assign wb_ack_out = ack_ff;
    assign wb_dat_out = dat_ff;

endmodule // bfs_top

//--- sim/bfs_top_assertions.sv
// Port checker of the supervisor, bound into its top module
module bfs_chk #(
    parameter OC_CYC = 1000,
    parameter OV_CYC = 200
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rstn_in,
    // Bus
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    // Pins
    input wire current_limit_sense_above_in,
    input wire feedback_pin_above_ov_rise_in,
    input wire feedback_pin_below_uv_in,
    input wire enable_below_fall_in,
    input wire bias_supply_pin_below_por_in,
    input wire over_temp_in,
    input wire high_side_gate_out,
    input wire low_side_gate_out,
    input wire power_good_output_out,
    input wire light_load_diode_mode_out,
    input wire window_widen_out
);
    // ****************************************************************
    // Dwell tracking and assertions
    // ****************************************************************
    logic [10:0] oc_run_ff;
    logic [10:0] ov_run_ff;
    logic [10:0] uv_run_ff;
    logic long_ff;
    wire rel = enable_below_fall_in | bias_supply_pin_below_por_in;
    // One sample of slack covers the synchroniser's edge alignment
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oc_run_ff <= 11'h000;
            ov_run_ff <= 11'h000;
            uv_run_ff <= 11'h000;
            long_ff <= 1'b0;
        end else begin
            oc_run_ff <= current_limit_sense_above_in ?
                oc_run_ff + {10'h000, ~&oc_run_ff} : 11'h000;
            ov_run_ff <= feedback_pin_above_ov_rise_in ?
                ov_run_ff + {10'h000, ~&ov_run_ff} : 11'h000;
            uv_run_ff <= feedback_pin_below_uv_in ?
                uv_run_ff + {10'h000, ~&uv_run_ff} : 11'h000;
            if (rel) begin
                long_ff <= 1'b0;
            end else if (oc_run_ff >= OC_CYC - 1 || ov_run_ff >= OV_CYC - 1
                    || uv_run_ff >= OV_CYC - 1) begin
                long_ff <= 1'b1;
            end
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_ack;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    a_ack_one_cycle: assert property (s_req |=> s_ack)
        else $error("ack not a single cycle after request");
    a_ack_has_cause: assert property (
        wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    a_read_data_holds: assert property (
        !$past(wb_cyc_in && wb_stb_in) |-> $stable(wb_dat_out))
        else $error("read data changed while idle");
    a_widen_with_mode: assert property (
        window_widen_out == light_load_diode_mode_out)
        else $error("window widening differs from diode mode");
    a_release_stops: assert property (
        rel [*8] |-> !high_side_gate_out && !low_side_gate_out
        && !power_good_output_out)
        else $error("release did not stop the converter");
    a_hot_gates_low: assert property (
        over_temp_in [*8] |-> !high_side_gate_out && !low_side_gate_out)
        else $error("gates driven during over temperature");
    a_fault_high_off: assert property (
        !power_good_output_out [*2] |-> !high_side_gate_out)
        else $error("high gate on while power good low");
    a_fault_dwell: assert property (
        $fell(power_good_output_out) && !rel |-> long_ff)
        else $error("fault declared before its dwell time");
endmodule // bfs_chk

bind bfs_top bfs_chk #(.OC_CYC(OC_CYC), .OV_CYC(OV_CYC)) u_chk (
    .core_clk_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out,
    .wb_ack_out, .current_limit_sense_above_in,
    .feedback_pin_above_ov_rise_in, .feedback_pin_below_uv_in,
    .enable_below_fall_in, .bias_supply_pin_below_por_in, .over_temp_in,
    .high_side_gate_out, .low_side_gate_out, .power_good_output_out,
    .light_load_diode_mode_out, .window_widen_out);

//--- sim/bfs_stage.sv
// Model of the modulator and the low-side current sensing
module bfs_stage (
    // Clock and reset
    input wire core_clk_in,
    input wire rstn_in,
    // Bench control
    input wire neg_en_in,
    // Toward the supervisor
    output logic pwm_high_req_out,
    output logic pwm_low_req_out,
    output logic neg_current_out
);
    // ****************************************************************
    // Fixed sixteen-clock switching cycle
    // ****************************************************************
    logic [3:0] ph_ff;
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ph_ff <= 4'h0;
        end else begin
            ph_ff <= ph_ff + 4'h1;
        end
    end
    // One count of dead time on each side of the low request
    assign pwm_high_req_out = ph_ff < 4'h4;
    assign pwm_low_req_out = ph_ff > 4'h4 && ph_ff < 4'hF;
    // Reverse current can only be sensed while the low-side request is high
    assign neg_current_out = neg_en_in && pwm_low_req_out;
endmodule // bfs_stage

//--- sim/bfs_tb.sv
// Self-checking bench of the supervisor
`include "bfs_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Bench
    // ****************************************************************
    localparam int OCC = 20;
    localparam int OVC = 10;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wb_req = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wd = 32'h0;
    logic [2:0] flt = 3'h0;
    logic bfall = 1'b0, enb = 1'b0, por = 1'b0, ot = 1'b0;
    logic negv = 1'b0, nege = 1'b0;
    wire [31:0] rdat;
    wire ack, pwmh, pwml, negc, hs, ls, pg, light_load_diode_mode, wid, irq;
    int n_mismatch = 0;
    int checked = 0;
    always #5 core_clk_in = ~core_clk_in;
    bfs_stage u_stage (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .neg_en_in(nege), .pwm_high_req_out(pwmh), .pwm_low_req_out(pwml),
        .neg_current_out(negc));
    bfs_top #(.OC_CYC(OCC), .OV_CYC(OVC)) uut (.core_clk_in(core_clk_in),
        .rstn_in(rstn_in), .wb_cyc_in(wb_req), .wb_stb_in(wb_req),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hF),
        .wb_dat_in(wb_wd), .wb_dat_out(rdat), .wb_ack_out(ack),
        .current_limit_sense_above_in(flt[0]),
        .feedback_pin_above_ov_rise_in(flt[1]),
        .feedback_pin_below_ov_fall_in(bfall),
        .feedback_pin_below_uv_in(flt[2]), .enable_below_fall_in(enb),
        .bias_supply_pin_below_por_in(por), .over_temp_in(ot),
        .neg_current_in(negc), .neg_voltage_in(negv),
        .pwm_high_req_in(pwmh), .pwm_low_req_in(pwml),
        .high_side_gate_out(hs), .low_side_gate_out(ls),
        .power_good_output_out(pg), .light_load_diode_mode_out(light_load_diode_mode),
        .window_widen_out(wid), .irq_out(irq));
    task automatic complete_run;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang;
        n_mismatch = n_mismatch + 1;
        complete_run();
    endtask
    task automatic clks(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // Wait for n rising edges of the high-side request
    task automatic starts(input int n);
        int i;
        repeat (n) begin
            for (i = 0; i < 40 && pwmh === 1'b1; i++) clks(1);
            if (i == 40) hang();
            for (i = 0; i < 40 && pwmh !== 1'b1; i++) clks(1);
            if (i == 40) hang();
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge core_clk_in);
        wb_req <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wd <= d;
        i = 0;
        do begin
            @(posedge core_clk_in);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) hang();
        q = rdat;
        wb_req <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        rd_chk(`BFS_CTRL_ADDR, 32'h0);
        rd_chk(`BFS_IRQ_EN_ADDR, 32'h0);
        wr(`BFS_CTRL_ADDR, 32'h1);
        rd_chk(`BFS_CTRL_ADDR, 32'h1);
        wr(8'h40, 32'hFF);
        rd_chk(8'h40, 32'h0);
        rd_chk(`BFS_STATUS_ADDR, 32'h20);
    endtask
    task automatic t_dem;
        starts(1);
        nege <= 1'b1;
        starts(7);
        nege <= 1'b0;
        starts(1);
        nege <= 1'b1;
        starts(7);
        clks(8);
        chk(light_load_diode_mode, 0);
        rd_chk(`BFS_DEM_CNT_ADDR, 32'h7);
        starts(2);
        clks(8);
        chk(light_load_diode_mode, 1);
        chk(wid, 1);
        nege <= 1'b0;
        negv <= 1'b1;
        clks(4);
        chk(light_load_diode_mode, 1);
        starts(1);
        negv <= 1'b0;
        clks(8);
        chk(light_load_diode_mode, 0);
        chk(wid, 0);
        rd_chk(`BFS_IRQ_STAT_ADDR, 32'h30);
        wr(`BFS_IRQ_CLR_ADDR, 32'h3F);
        rd_chk(`BFS_IRQ_STAT_ADDR, 32'h0);
    endtask
    // Short excursion, trip, latch, interrupt, then release
    task automatic t_fault(input int k, input int thr, input logic [31:0] st);
        flt[k] <= 1'b1;
        clks(thr / 2);
        flt[k] <= 1'b0;
        clks(10);
        chk(pg, 1);
        flt[k] <= 1'b1;
        clks(thr + 10);
        chk(pg, 0);
        chk(hs, 0);
        chk(ls, k == 1);
        rd_chk(`BFS_STATUS_ADDR, st);
        if (k == 1) begin
            flt[1] <= 1'b0;
            bfall <= 1'b1;
            clks(thr / 2);
            chk(ls, 1);
            // Dwell, synchroniser and two register stages to the gate
            clks(thr + 10);
            chk(ls, 0);
            bfall <= 1'b0;
            flt[1] <= 1'b1;
            clks(thr + 10);
            chk(ls, 1);
        end
        flt[k] <= 1'b0;
        clks(20);
        chk(pg, 0);
        wr(`BFS_IRQ_EN_ADDR, 32'h1 << k);
        clks(1);
        chk(irq, 1);
        wr(`BFS_IRQ_EN_ADDR, 32'h0);
        clks(1);
        chk(irq, 0);
        wr(`BFS_IRQ_CLR_ADDR, 32'h3F);
        rd_chk(`BFS_IRQ_STAT_ADDR, 32'h0);
        if (k == 1) por <= 1'b1;
        else enb <= 1'b1;
        clks(12);
        por <= 1'b0;
        enb <= 1'b0;
        clks(12);
        chk(pg, 1);
        rd_chk(`BFS_STATUS_ADDR, 32'h20);
    endtask
    task automatic t_ot;
        ot <= 1'b1;
        clks(12);
        chk(hs, 0);
        chk(ls, 0);
        chk(pg, 1);
        rd_chk(`BFS_STATUS_ADDR, 32'h28);
        ot <= 1'b0;
        clks(12);
        rd_chk(`BFS_STATUS_ADDR, 32'h20);
    endtask
    initial begin
        clks(5);
        rstn_in <= 1'b1;
        t_regs();
        t_dem();
        t_fault(0, OCC, 32'h01);
        t_fault(1, OVC, 32'h42);
        t_fault(2, OVC, 32'h04);
        t_ot();
        complete_run();
    end
endmodule // testbench
